// file: system_watchdog_timer.sv
// software-serviced watchdog with keyed reload, nmi and system reset
// assumes tick is a one-cycle pulse on ref_clk every 10.24 ms and
// debug_halt comes from outside the clock domain
`timescale 1ns/1ps
`include "wdt_regs.svh"

// Contract
// - a counter write is taken only when its key bits 15:9 are all zero.
// - a taken write loads bits 8:0, sign bit included, into the counter.
// - a counter read returns the live count with the key bits as zero.
// - unless frozen the count falls by one on each 10.24 ms tick.
// - the count is 9 bits and with mode clear wraps from zero to 0x1FF, 0x1FE and on.
// - bit 8 reads one while the count is negative and is writable.
// - with mode clear, the count reaching zero raises the nmi.
// - with mode clear, the count at 0x1F0 gives a reset and reloads 0xFF.
// - with mode set, a count at or below zero resets and reloads 0xFF.
// - software can set mode but only a reset or soft reset clears it.
// - with mode clear software freezes and resumes; with mode set not.
// - the count is always frozen while the processor is halted.
module system_watchdog_timer
	import wdt_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire reg_req_s bus_req,
	output reg_data_t rdata,
	// timing and system inputs
	input wire logic tick,
	input wire logic debug_halt,
	input wire logic soft_rst,
	// system outputs
	output logic nmi,
	output logic wdog_rst,
	output logic irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	count_t count;
	count_t next_count;
	logic mode;
	logic next_mode;
	logic frz;
	logic next_frz;
	logic was_zero;
	logic next_was_zero;
	logic next_nmi;
	logic next_wdog_rst;
	reg_data_t next_rdata;

	logic halt_sync;
	logic wr_cnt;
	logic wr_ctl;
	logic wr_fset;
	logic wr_fclr;
	logic wr_stat;
	logic wr_mask;
	logic key_ok;
	logic freeze_eff;
	logic dec_ok;
	logic expire;
	logic nmi_hit;
	wdt_evt_s evt;
	logic [`WDT_EVT_COUNT-1:0] evt_status;
	logic [`WDT_EVT_COUNT-1:0] evt_mask;

	// ----------------------------------------------------------------
	// halt input crossing
	// ----------------------------------------------------------------
	wdt_sync2 u_halt_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in(debug_halt),
		.sync_out(halt_sync)
	);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	always_comb begin
		wr_cnt = bus_req.wr && (bus_req.addr == `WDT_COUNTER_OFS);
		wr_ctl = bus_req.wr && (bus_req.addr == `WDT_CONTROL_OFS);
		wr_fset = bus_req.wr && (bus_req.addr == `WDT_FRZ_SET_OFS);
		wr_fclr = bus_req.wr && (bus_req.addr == `WDT_FRZ_CLR_OFS);
		wr_stat = bus_req.wr && (bus_req.addr == `WDT_STATUS_OFS);
		wr_mask = bus_req.wr && (bus_req.addr == `WDT_MASK_OFS);
	end

	assign key_ok =
		bus_req.wdata[`WDT_KEY_MSB:`WDT_KEY_LSB] == `WDT_KEY_OPEN;

	// ----------------------------------------------------------------
	// freeze, expiry and events
	// ----------------------------------------------------------------
	// freeze sources
	assign freeze_eff = halt_sync || (frz && !mode);
	assign dec_ok = tick && !freeze_eff;

	assign expire = mode
		? (count == `WDT_COUNT_NMI || count[`WDT_SIGN_BIT])
		: (count == `WDT_COUNT_RST);

	assign nmi_hit = !mode && (count == `WDT_COUNT_NMI) && !was_zero;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_count = count;
		next_mode = mode;
		next_frz = frz;
		next_was_zero = (count == `WDT_COUNT_NMI);
		next_nmi = nmi_hit;
		next_wdog_rst = expire;
		if (expire) begin
			next_count = `WDT_COUNT_RELOAD;
		end else if (wr_cnt && key_ok) begin
			next_count = bus_req.wdata[`WDT_SIGN_BIT:0];
		end else if (dec_ok) begin
			next_count = count - `WDT_COUNT_STEP;
		end
		if (expire || soft_rst)
			next_mode = 1'b0;
		else if (wr_ctl && bus_req.wdata[`WDT_MODE_BIT])
			next_mode = 1'b1;
		if (expire || soft_rst)
			next_frz = 1'b0;
		else if (wr_fset && bus_req.wdata[`WDT_FRZ_BIT] && !mode)
			next_frz = 1'b1;
		else if (wr_fclr && bus_req.wdata[`WDT_FRZ_BIT])
			next_frz = 1'b0;
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = '0;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`WDT_COUNTER_OFS: next_rdata = {7'h00, count};
				`WDT_CONTROL_OFS: next_rdata = {15'h0000, mode};
				`WDT_STATUS_OFS: next_rdata = {14'h0000, evt_status};
				`WDT_MASK_OFS: next_rdata = {14'h0000, evt_mask};
				`WDT_FRZ_SET_OFS: next_rdata = {15'h0000, frz};
				default: next_rdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count <= `WDT_COUNT_RESET;
			mode <= 1'b0;
			frz <= 1'b0;
			was_zero <= 1'b0;
			nmi <= 1'b0;
			wdog_rst <= 1'b0;
			rdata <= '0;
		end else begin
			count <= next_count;
			mode <= next_mode;
			frz <= next_frz;
			was_zero <= next_was_zero;
			nmi <= next_nmi;
			wdog_rst <= next_wdog_rst;
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// event status and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		evt.nmi = nmi;
		evt.rst = wdog_rst;
	end

	wdt_irq_status #(
		.N(`WDT_EVT_COUNT)
	) u_irq (
		.ref_clk(ref_clk),
		.rst(rst),
		.evt(evt),
		.wr_status(wr_stat),
		.wr_mask(wr_mask),
		.wdata(bus_req.wdata[`WDT_EVT_COUNT-1:0]),
		.status(evt_status),
		.mask(evt_mask),
		.irq(irq)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_key_reject: assert property (
		@(posedge ref_clk) disable iff (rst)
		wr_cnt && !key_ok && !expire && !dec_ok |=> $stable(count)
	) else $error("counter changed on a locked write");

	a_key_accept: assert property (
		@(posedge ref_clk) disable iff (rst)
		wr_cnt && key_ok && !expire
		|=> count == $past(bus_req.wdata[8:0])
	) else $error("keyed write did not load the counter");

	a_read_live: assert property (
		@(posedge ref_clk) disable iff (rst)
		bus_req.rd && bus_req.addr == `WDT_COUNTER_OFS
		|=> rdata == {7'h00, $past(count)}
	) else $error("counter read is not the live count");

	a_tick_dec: assert property (
		@(posedge ref_clk) disable iff (rst)
		dec_ok && !wr_cnt && !expire
		|=> count == $past(count) - 9'h001
	) else $error("counter did not fall by one on a tick");

	a_no_tick: assert property (
		@(posedge ref_clk) disable iff (rst)
		!tick && !wr_cnt && !expire |=> $stable(count)
	) else $error("counter moved without a tick");

	a_wrap_zero: assert property (
		@(posedge ref_clk) disable iff (rst)
		count == 9'h000 && !mode && dec_ok && !wr_cnt
		|=> count == 9'h1FF && rdata[8] == 1'b0
	) else $error("counter did not wrap to 1FF");

	a_sign_read: assert property (
		@(posedge ref_clk) disable iff (rst)
		bus_req.rd && bus_req.addr == `WDT_COUNTER_OFS && count[8]
		|=> rdata[8] && rdata[15:9] == 7'h00
	) else $error("negative count read without sign bit");

	a_nmi_zero: assert property (
		@(posedge ref_clk) disable iff (rst)
		!mode && count == 9'h000 && !was_zero
		|=> nmi ##1 !nmi
	) else $error("nmi not a single pulse at zero");

	a_rst_reload: assert property (
		@(posedge ref_clk) disable iff (rst)
		!mode && count == 9'h1F0 |=> wdog_rst && count == 9'h0FF
	) else $error("no reset and reload at minus sixteen");

	a_mode1_rst: assert property (
		@(posedge ref_clk) disable iff (rst)
		mode && (count == 9'h000 || count[8])
		|=> wdog_rst && !nmi && count == 9'h0FF && !mode
	) else $error("mode one expiry did not reset directly");

	a_mode_sticky: assert property (
		@(posedge ref_clk) disable iff (rst)
		mode && !expire && !soft_rst |=> mode
	) else $error("mode bit cleared without a reset");

	a_soft_freeze: assert property (
		@(posedge ref_clk) disable iff (rst)
		frz && !mode && !wr_cnt && !expire |=> $stable(count)
	) else $error("counter moved while frozen by software");

	a_mode1_runs: assert property (
		@(posedge ref_clk) disable iff (rst)
		mode && frz && !halt_sync && tick && !wr_cnt && !expire
		|=> count == $past(count) - 9'h001
	) else $error("software freeze acted with mode set");

	a_halt_freeze: assert property (
		@(posedge ref_clk) disable iff (rst)
		halt_sync && !wr_cnt && !expire |=> $stable(count)
	) else $error("counter moved while halted");

endmodule : system_watchdog_timer

// file: system_watchdog_timer_tb_top.sv
// self-checking bench for the watchdog against an integer model
// assumes the register map of wdt_regs.svh and a 40 MHz ref_clk
`timescale 1ns/1ps
`include "wdt_regs.svh"

module system_watchdog_timer_tb_top
	import wdt_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	reg_req_s bus_req = '0;
	reg_data_t rdata;
	logic tick = 1'b0;
	logic debug_halt = 1'b0;
	logic soft_rst = 1'b0;
	logic nmi, wdog_rst, irq;
	int nmi_seen, rst_seen;
	int bad_count = 0;
	int tests_run = 0;
	int cnt = 'hFF;
	int mode = 0;
	int frz = 0;
	int halt = 0;
	logic [31:0] xs_state = 32'h0000_0004;
	reg_data_t rd_val;

	always #12.5 ref_clk = ~ref_clk;

	system_watchdog_timer dut (.ref_clk(ref_clk), .rst(rst),
		.bus_req(bus_req), .rdata(rdata), .tick(tick),
		.debug_halt(debug_halt), .soft_rst(soft_rst), .nmi(nmi),
		.wdog_rst(wdog_rst), .irq(irq));

	wdt_sys_model sys (.ref_clk(ref_clk), .rst(rst), .nmi(nmi),
		.wdog_rst(wdog_rst), .nmi_seen(nmi_seen), .rst_seen(rst_seen));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		xs_state ^= xs_state << 13;
		xs_state ^= xs_state >> 17;
		xs_state ^= xs_state << 5;
		return xs_state;
	endfunction : xs

	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(logic [31:0] a, logic [15:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req <= '0;
		// let the write settle before anything looks at the outputs
		#1;
	endtask : wr

	task automatic rchk(string name, logic [31:0] a, logic [15:0] exp);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req <= '0;
		#1;
		chk(name, exp, rdata);
	endtask : rchk

	// one tick, then the model decides which requests must follow
	task automatic tk();
		int en, er, xn, xr;
		@(posedge ref_clk);
		tick <= 1'b1;
		@(posedge ref_clk);
		tick <= 1'b0;
		en = nmi_seen;
		er = rst_seen;
		if (!(halt || (frz && !mode)))
			cnt = (cnt - 1) & 'h1FF;
		repeat (4) @(posedge ref_clk);
		xn = (!mode && cnt == 0);
		xr = mode ? (cnt == 0 || cnt >= 'h100) : (cnt == 'h1F0);
		chk("nmi", 16'(xn), 16'(nmi_seen - en));
		chk("wdog_rst", 16'(xr), 16'(rst_seen - er));
		if (xr) begin
			cnt = 'hFF;
			mode = 0;
			frz = 0;
		end
	endtask : tk

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin : main
		logic [31:0] r;
		logic [6:0] k;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		rchk("count", `WDT_COUNTER_OFS, 16'h00FF);
		rchk("control", `WDT_CONTROL_OFS, 16'h0000);
		rchk("status", `WDT_STATUS_OFS, 16'h0000);
		rchk("unmapped", 32'h5000_310C, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			r = xs();
			cnt = r % 'h1EF + 1;
			wr(`WDT_COUNTER_OFS, 16'(cnt));
			rchk("count", `WDT_COUNTER_OFS, 16'(cnt));
			k = 7'((r >> 16) % 127 + 1);
			wr(`WDT_COUNTER_OFS, {k, r[8:0]});
			rchk("keyed", `WDT_COUNTER_OFS, 16'(cnt));
		end
		wr(`WDT_MASK_OFS, 16'h0001);
		wr(`WDT_COUNTER_OFS, 16'h0002);
		cnt = 2;
		tk();
		tk();
		rchk("status", `WDT_STATUS_OFS, 16'h0001);
		chk("irq", 16'h0001, 16'(irq));
		tk();
		rchk("wrap", `WDT_COUNTER_OFS, 16'h01FF);
		repeat (15) tk();
		rchk("reload", `WDT_COUNTER_OFS, 16'h00FF);
		rchk("status", `WDT_STATUS_OFS, 16'h0003);
		wr(`WDT_STATUS_OFS, 16'h0001);
		chk("irq", 16'h0000, 16'(irq));
		wr(`WDT_MASK_OFS, 16'h0003);
		chk("irq", 16'h0001, 16'(irq));
		wr(`WDT_STATUS_OFS, 16'h0002);
		chk("irq", 16'h0000, 16'(irq));
		wr(`WDT_COUNTER_OFS, 16'h0005);
		cnt = 5;
		wr(`WDT_FRZ_SET_OFS, 16'h0001);
		frz = 1;
		tk();
		rchk("frozen", `WDT_COUNTER_OFS, 16'h0005);
		wr(`WDT_FRZ_CLR_OFS, 16'h0001);
		frz = 0;
		tk();
		rchk("resumed", `WDT_COUNTER_OFS, 16'h0004);
		debug_halt <= 1'b1;
		halt = 1;
		repeat (3) @(posedge ref_clk);
		tk();
		rchk("halted", `WDT_COUNTER_OFS, 16'h0004);
		debug_halt <= 1'b0;
		halt = 0;
		repeat (3) @(posedge ref_clk);
		// freeze left set from mode zero must not hold the count in mode one
		wr(`WDT_FRZ_SET_OFS, 16'h0001);
		frz = 1;
		wr(`WDT_CONTROL_OFS, 16'h0001);
		mode = 1;
		wr(`WDT_CONTROL_OFS, 16'h0000);
		rchk("mode", `WDT_CONTROL_OFS, 16'h0001);
		rchk("freeze", `WDT_FRZ_SET_OFS, 16'h0001);
		tk();
		rchk("count", `WDT_COUNTER_OFS, 16'h0003);
		wr(`WDT_COUNTER_OFS, 16'h0001);
		cnt = 1;
		tk();
		rchk("mode", `WDT_CONTROL_OFS, 16'h0000);
		rchk("freeze", `WDT_FRZ_SET_OFS, 16'h0000);
		wr(`WDT_CONTROL_OFS, 16'h0001);
		mode = 1;
		wr(`WDT_FRZ_SET_OFS, 16'h0001);
		rchk("freeze", `WDT_FRZ_SET_OFS, 16'h0000);
		@(posedge ref_clk);
		soft_rst <= 1'b1;
		@(posedge ref_clk);
		soft_rst <= 1'b0;
		rchk("mode", `WDT_CONTROL_OFS, 16'h0000);
		wrap_up();
	end

	initial begin : watchdog
		#2_000_000;
		bad_count++;
		wrap_up();
	end
endmodule : system_watchdog_timer_tb_top

// file: wdt_irq_status.sv
// sticky event status with write-one-to-clear, mask and level interrupt
// assumes events are one-cycle pulses on the same clock
`timescale 1ns/1ps

module wdt_irq_status #(
	parameter int N = 2
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// events and register writes
	input wire logic [N-1:0] evt,
	input wire logic wr_status,
	input wire logic wr_mask,
	input wire logic [N-1:0] wdata,
	// state and interrupt
	output logic [N-1:0] status,
	output logic [N-1:0] mask,
	output logic irq
);

	logic [N-1:0] next_status;
	logic [N-1:0] next_mask;

	// a new event wins over a clear in the same cycle
	for (genvar i = 0; i < N; i++) begin : g_bit
		always_comb begin
			next_status[i] = status[i];
			if (wr_status && wdata[i])
				next_status[i] = 1'b0;
			if (evt[i])
				next_status[i] = 1'b1;
			next_mask[i] = wr_mask ? wdata[i] : mask[i];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status <= '0;
			mask <= '0;
		end else begin
			status <= next_status;
			mask <= next_mask;
		end
	end

	assign irq = |(status & mask);

endmodule : wdt_irq_status

// file: wdt_pkg.sv
// types shared by the watchdog modules
// assumes the offsets and fields of wdt_regs.svh
package wdt_pkg;

	typedef logic [8:0] count_t;
	typedef logic [15:0] reg_data_t;

	// one register port access
	typedef struct packed {
		logic [31:0] addr;
		reg_data_t wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	// watchdog events, one bit each
	typedef struct packed {
		logic rst;
		logic nmi;
	} wdt_evt_s;

endpackage : wdt_pkg

// file: wdt_regs.svh
// register offsets, field positions, reset values and timing of the watchdog
// assumes a 16-bit register port with full 32-bit byte addresses
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WDT_COUNTER_OFS 32'h5000_3100
`define WDT_CONTROL_OFS 32'h5000_3102
`define WDT_STATUS_OFS 32'h5000_3104
`define WDT_MASK_OFS 32'h5000_3106
`define WDT_FRZ_SET_OFS 32'h5000_3108
`define WDT_FRZ_CLR_OFS 32'h5000_310A

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WDT_KEY_MSB 15
`define WDT_KEY_LSB 9
`define WDT_KEY_OPEN 7'h00
`define WDT_SIGN_BIT 8
`define WDT_MODE_BIT 0
`define WDT_FRZ_BIT 0
`define WDT_EVT_NMI_BIT 0
`define WDT_EVT_RST_BIT 1
`define WDT_EVT_COUNT 2

// ----------------------------------------------------------------
// reset values and count thresholds
// ----------------------------------------------------------------
`define WDT_COUNT_RESET 9'h0FF
`define WDT_COUNT_RELOAD 9'h0FF
`define WDT_COUNT_NMI 9'h000
`define WDT_COUNT_RST 9'h1F0
`define WDT_COUNT_STEP 9'h001
`define WDT_COUNT_WRAP 9'h1FF

// ----------------------------------------------------------------
// timing: one tick every 10.24 ms at a 25 ns clock
// ----------------------------------------------------------------
`define WDT_TICK_PERIOD_US 10240
`define WDT_CLK_PERIOD_NS 25
`define WDT_TICK_CYCLES ((`WDT_TICK_PERIOD_US * 1000) / `WDT_CLK_PERIOD_NS)

`endif

// file: wdt_sync2.sv
// two-flop synchroniser for a level from outside the clock domain
// assumes the level is stable for well over two clock periods
`timescale 1ns/1ps

module wdt_sync2 (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);

	logic meta;
	logic next_meta;
	logic next_sync_out;

	always_comb begin
		next_meta = async_in;
		next_sync_out = meta;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= next_meta;
			sync_out <= next_sync_out;
		end
	end

endmodule : wdt_sync2

// file: wdt_sys_model.sv
// far side of the watchdog: processor nmi input and system reset controller
// assumes nmi and wdog_rst are one-cycle pulses on ref_clk
`timescale 1ns/1ps

module wdt_sys_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// requests from the watchdog
	input wire logic nmi,
	input wire logic wdog_rst,
	// pulses taken so far
	output int nmi_seen,
	output int rst_seen
);
	// each request is taken once per cycle that it is high
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			nmi_seen <= 0;
			rst_seen <= 0;
		end else begin
			nmi_seen <= nmi_seen + int'(nmi);
			rst_seen <= rst_seen + int'(wdog_rst);
		end
	end
endmodule : wdt_sys_model
